// *** rtl/card_trail_pkg.sv ***
package card_trail_pkg;

   // frame delays in carrier cycles (last reader data bit one / zero)
   localparam logic [11:0] MIN_DELAY_ONE = 12'h4D4; // 1236
   localparam logic [11:0] MIN_DELAY_ZERO = 12'h494; // 1172
   localparam logic [11:0] NOM_DELAY_ONE = 12'hC54; // 3156
   localparam logic [11:0] NOM_DELAY_ZERO = 12'hC14; // 3092

   // one bit period is 128 carrier cycles
   localparam logic [6:0] ETU_LAST = 7'h7F;

   // reader command bytes
   localparam logic [7:0] CMD_WAKE_A = 8'h52;
   localparam logic [7:0] CMD_HALT = 8'h50;
   localparam logic [7:0] CMD_ZERO = 8'h00;
   localparam logic [7:0] CMD_WAKE_B = 8'h05;
   localparam logic [7:0] CMD_WAKE_B_PARAM = 8'h08;
   localparam logic [7:0] CMD_CASCADE1 = 8'h93;
   localparam logic [7:0] CMD_ANTICOL = 8'h20;
   localparam logic [7:0] CMD_SELECT = 8'h70;
   localparam logic [7:0] CMD_ATS_REQ = 8'hE0;
   localparam logic [7:0] CMD_ATS_PARAM = 8'h80;
   localparam logic [7:0] IBLOCK_MASK = 8'hE2;
   localparam logic [7:0] IBLOCK_CODE = 8'h02;

   // expected received lengths, crc bytes already stripped
   localparam logic [3:0] LEN_SHORT = 4'h1;
   localparam logic [3:0] LEN_TWO = 4'h2;
   localparam logic [3:0] LEN_WAKE_B = 4'h3;
   localparam logic [3:0] LEN_SELECT = 4'h7;

   // end-of-test command code for the removal procedure (arbitrary value)
   localparam logic [7:0] EOT_REMOVAL = 8'h01;

   typedef enum logic [2:0] {
      RESP_ATQA, RESP_UID, RESP_SAK, RESP_ATS, RESP_DIR, RESP_EOT
   } resp_t;

   typedef enum logic [3:0] {
      TR_POLL, TR_HALT, TR_WAKE_B, TR_WAKE2, TR_ANTICOL, TR_SELECT,
      TR_ATS, TR_DIR, TR_LOOP, TR_END, TR_DONE
   } trail_t;

   typedef enum logic [1:0] {
      TX_IDLE, TX_WAIT, TX_SEND
   } tx_t;

   // byte idx of a response frame
   function automatic logic [7:0] respByte(resp_t resp, logic [4:0] idx, logic [7:0] eot);
      logic [7:0] b;
      b = 8'h00;
      case (resp)
         RESP_ATQA: b = (idx == 5'h00) ? 8'h08 : 8'h03;
         RESP_UID: begin
            case (idx)
               5'h00: b = 8'h27;
               5'h01: b = 8'hE9;
               5'h02: b = 8'h3B;
               5'h03: b = 8'h11;
               default: b = 8'hE4;
            endcase
         end
         RESP_SAK: b = 8'h20;
         RESP_ATS: begin
            case (idx)
               5'h00: b = 8'h05;
               5'h01: b = 8'h72;
               5'h02: b = 8'h80;
               5'h03: b = 8'h40;
               default: b = 8'h02;
            endcase
         end
         RESP_DIR: begin
            case (idx)
               5'h00: b = 8'h02;
               5'h01: b = 8'h00;
               5'h02: b = 8'hA4;
               5'h03: b = 8'h04;
               5'h04: b = 8'h00;
               5'h05: b = 8'h0C;
               5'h12: b = 8'h00;
               5'h13: b = 8'h90;
               5'h14: b = 8'h00;
               default: b = {3'h0, idx} - 8'h05;
            endcase
         end
         default: begin
            case (idx)
               5'h00: b = 8'h03;
               5'h01: b = eot;
               5'h02: b = 8'h90;
               default: b = 8'h00;
            endcase
         end
      endcase
      return b;
   endfunction

   // index of the last byte of a response
   function automatic logic [4:0] respLast(resp_t resp);
      case (resp)
         RESP_ATQA: return 5'h01;
         RESP_UID: return 5'h04;
         RESP_SAK: return 5'h00;
         RESP_ATS: return 5'h04;
         RESP_DIR: return 5'h14;
         default: return 5'h03;
      endcase
   endfunction

   // frames sent with crc, all but ATQA and UID
   function automatic logic respCrc(resp_t resp);
      return !(resp == RESP_ATQA || resp == RESP_UID);
   endfunction

   // delay before the start of frame
   function automatic logic [11:0] frameDelay(resp_t resp, logic lastBit);
      if (resp == RESP_ATS || resp == RESP_DIR || resp == RESP_EOT) begin
         return lastBit ? NOM_DELAY_ONE : NOM_DELAY_ZERO;
      end
      return lastBit ? MIN_DELAY_ONE : MIN_DELAY_ZERO;
   endfunction

endpackage

// *** rtl/word_buffer.sv ***
`timescale 1ns/1ps
`default_nettype none
module word_buffer #(
   parameter int WIDTH = 9,
   parameter int DEPTH = 2
) (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic ce,
   input wire logic flush,
   input wire logic inValid,
   input wire logic [WIDTH-1:0] inData,
   output logic inReady,
   output logic outValid,
   output logic [WIDTH-1:0] outData,
   input wire logic outReady
);
   localparam int AW = $clog2(DEPTH);

   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [AW-1:0] wr;
      logic [AW-1:0] rd;
      logic [AW:0] count;
   } buf_t;

   buf_t r, n;
   logic push;
   logic pop;

   // handshakes from the fill count
   assign inReady = (r.count != (AW+1)'(DEPTH));
   assign outValid = (r.count != '0);
   assign outData = r.mem[r.rd];
   assign push = inValid & inReady;
   assign pop = outValid & outReady;

   // next buffer contents
   always_comb begin
      n = r;
      if (push) begin
         n.mem[r.wr] = inData;
         n.wr = (r.wr == AW'(DEPTH - 1)) ? '0 : AW'(r.wr + 1'b1);
      end
      if (pop) begin
         n.rd = (r.rd == AW'(DEPTH - 1)) ? '0 : AW'(r.rd + 1'b1);
      end
      n.count = (AW+1)'(r.count + (AW+1)'(push) - (AW+1)'(pop));
      if (flush) begin
         n.wr = '0;
         n.rd = '0;
         n.count = '0;
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         r <= '0;
      end else if (ce) begin
         r <= n;
      end
   end
endmodule
`default_nettype wire

// *** rtl/type_a_card_emulator_trail.sv ***
`timescale 1ns/1ps
`default_nettype none
module type_a_card_emulator_trail
   import card_trail_pkg::*;
#(
   parameter logic [7:0] END_OF_TEST_COMMAND = EOT_REMOVAL
) (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic ce,
   input wire logic carrierClk,
   input wire logic carrierPresent,
   input wire logic rxValid,
   input wire logic [7:0] rxByte,
   input wire logic rxEnd,
   input wire logic rxShort,
   input wire logic rxTypeB,
   input wire logic rxCrcOk,
   input wire logic rxLastBit,
   output logic txSof,
   output logic txValid,
   output logic [7:0] txByte,
   output logic txLast,
   input wire logic txReady,
   output logic txAppendCrc,
   output logic bitTick,
   output logic trailDone
);

   typedef struct packed {
      logic [1:0] carSync;
      logic carPrev;
      logic [1:0] presSync;
      trail_t trail;
      logic pastWakeB;
      logic [7:0] rx0;
      logic [7:0] rx1;
      logic [7:0] rx2;
      logic [3:0] rxCount;
      tx_t tx;
      resp_t resp;
      logic [11:0] delayTarget;
      logic [11:0] delayCnt;
      logic [4:0] idx;
      logic frameActive;
      logic [6:0] etu;
      logic sof;
      logic tick;
      logic crc;
   } state_t;

   state_t r, n;
   logic carEdge;
   logic present;
   logic pushValid;
   logic pushReady;
   logic [8:0] pushData;
   logic [8:0] outData;
   logic txDone;
   logic typeA2;

   // carrier edges and presence, both after two flops
   assign carEdge = r.carSync[1] & ~r.carPrev;
   assign present = r.presSync[1];
   assign txDone = txValid & txReady & txLast;

   // a two-byte Type A frame with good crc
   assign typeA2 = !rxTypeB && !rxShort && rxCrcOk && (r.rxCount == LEN_TWO);

   // bytes of the response that is being sent
   assign pushValid = (r.tx == TX_SEND) && present;
   assign pushData = {r.idx == respLast(r.resp), respByte(r.resp, r.idx, END_OF_TEST_COMMAND)};

   word_buffer #(.WIDTH(9), .DEPTH(2)) txBuffer (
      .clk(clk),
      .reset_n(reset_n),
      .ce(ce),
      .flush(!present),
      .inValid(pushValid),
      .inData(pushData),
      .inReady(pushReady),
      .outValid(txValid),
      .outData(outData),
      .outReady(txReady)
   );

   assign txByte = outData[7:0];
   assign txLast = outData[8];
   assign txSof = r.sof;
   assign bitTick = r.tick;
   assign txAppendCrc = r.crc;
   assign trailDone = (r.trail == TR_DONE);

   // trail interpreter, frame delay and send sequencing
   always_comb begin
      n = r;
      n.carSync = {r.carSync[0], carrierClk};
      n.presSync = {r.presSync[0], carrierPresent};
      n.carPrev = r.carSync[1];
      n.sof = 1'b0;
      n.tick = 1'b0;

      // collect the leading bytes of a reader frame
      if (rxValid) begin
         if (r.rxCount == 4'h0) begin
            n.rx0 = rxByte;
         end else if (r.rxCount == 4'h1) begin
            n.rx1 = rxByte;
         end else if (r.rxCount == 4'h2) begin
            n.rx2 = rxByte;
         end
         if (r.rxCount != 4'hF) begin
            n.rxCount = r.rxCount + 4'h1;
         end
      end

      // match the finished frame against the next trail step
      if (rxEnd) begin
         n.rxCount = 4'h0;
         if (r.tx == TX_IDLE && !r.frameActive) begin
            n.tx = TX_WAIT;
            n.delayCnt = 12'h000;
            case (r.trail)
               TR_POLL: begin
                  if (rxShort && r.rxCount == LEN_SHORT && r.rx0 == CMD_WAKE_A) begin
                     n.resp = RESP_ATQA;
                     n.trail = TR_HALT;
                  end else begin
                     n.tx = TX_IDLE;
                  end
               end
               TR_HALT: begin
                  n.tx = TX_IDLE;
                  if (typeA2 && r.rx0 == CMD_HALT && r.rx1 == CMD_ZERO) begin
                     n.trail = TR_WAKE_B;
                  end
               end
               TR_WAKE_B: begin
                  n.tx = TX_IDLE;
                  if (rxTypeB && r.rxCount == LEN_WAKE_B && r.rx0 == CMD_WAKE_B
                      && r.rx1 == CMD_ZERO && r.rx2 == CMD_WAKE_B_PARAM) begin
                     n.trail = TR_WAKE2;
                     n.pastWakeB = 1'b1;
                  end
               end
               TR_WAKE2: begin
                  if (rxShort && r.rxCount == LEN_SHORT && r.rx0 == CMD_WAKE_A) begin
                     n.resp = RESP_ATQA;
                     n.trail = TR_ANTICOL;
                  end else begin
                     n.tx = TX_IDLE;
                  end
               end
               TR_ANTICOL: begin
                  if (!rxTypeB && !rxShort && r.rxCount == LEN_TWO
                      && r.rx0 == CMD_CASCADE1 && r.rx1 == CMD_ANTICOL) begin
                     n.resp = RESP_UID;
                     n.trail = TR_SELECT;
                  end else begin
                     n.tx = TX_IDLE;
                  end
               end
               TR_SELECT: begin
                  if (!rxTypeB && rxCrcOk && r.rxCount == LEN_SELECT
                      && r.rx0 == CMD_CASCADE1 && r.rx1 == CMD_SELECT) begin
                     n.resp = RESP_SAK;
                     n.trail = TR_ATS;
                  end else begin
                     n.tx = TX_IDLE;
                  end
               end
               TR_ATS: begin
                  if (typeA2 && r.rx0 == CMD_ATS_REQ && r.rx1 == CMD_ATS_PARAM) begin
                     n.resp = RESP_ATS;
                     n.trail = TR_DIR;
                  end else begin
                     n.tx = TX_IDLE;
                  end
               end
               TR_DIR, TR_LOOP: begin
                  if (!rxTypeB && !rxShort && rxCrcOk && r.rxCount != 4'h0
                      && (r.rx0 & IBLOCK_MASK) == IBLOCK_CODE) begin
                     n.resp = (r.trail == TR_DIR) ? RESP_DIR : RESP_EOT;
                     n.trail = (r.trail == TR_DIR) ? TR_LOOP : TR_END;
                  end else begin
                     n.tx = TX_IDLE;
                  end
               end
               default: begin
                  n.tx = TX_IDLE;
               end
            endcase
            n.delayTarget = frameDelay(n.resp, rxLastBit);
         end
      end

      // frame delay counted on carrier edges, then send
      case (r.tx)
         TX_WAIT: begin
            if (carEdge) begin
               n.delayCnt = r.delayCnt + 12'h001;
               if (n.delayCnt == r.delayTarget) begin
                  n.tx = TX_SEND;
                  n.sof = 1'b1;
                  n.idx = 5'h00;
                  n.etu = 7'h00;
                  n.frameActive = 1'b1;
                  n.crc = respCrc(r.resp);
               end
            end
         end
         TX_SEND: begin
            if (pushReady) begin
               n.idx = r.idx + 5'h01;
               if (r.idx == respLast(r.resp)) begin
                  n.tx = TX_IDLE;
               end
            end
         end
         default: begin
            // idle keeps the wait started by a matching frame end above
         end
      endcase

      // bit clock at carrier over 128 while a frame is out
      if (r.frameActive && carEdge) begin
         n.etu = r.etu + 7'h01;
         n.tick = (r.etu == ETU_LAST);
      end
      if (txDone) begin
         n.frameActive = 1'b0;
      end

      // carrier loss resets the card side
      if (!present) begin
         n.tx = TX_IDLE;
         n.frameActive = 1'b0;
         n.rxCount = 4'h0;
         if (r.trail == TR_END || r.trail == TR_DONE) begin
            n.trail = TR_DONE;
         end else if (r.pastWakeB) begin
            n.trail = TR_WAKE2;
         end else begin
            n.trail = TR_POLL;
         end
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         r <= '0;
      end else if (ce) begin
         r <= n;
      end
   end
endmodule
`default_nettype wire

// *** testbench/type_a_card_emulator_trail_chk.sv ***
`timescale 1ns/1ps
`default_nettype none
module type_a_card_emulator_trail_chk
   import card_trail_pkg::*;
(
   input wire logic clk,
   input wire logic reset_n,
   input wire logic ce,
   input wire logic carrierClk,
   input wire logic carrierPresent,
   input wire logic rxValid,
   input wire logic [7:0] rxByte,
   input wire logic rxEnd,
   input wire logic rxShort,
   input wire logic rxTypeB,
   input wire logic rxCrcOk,
   input wire logic rxLastBit,
   input wire logic txSof,
   input wire logic txValid,
   input wire logic [7:0] txByte,
   input wire logic txLast,
   input wire logic txReady,
   input wire logic txAppendCrc,
   input wire logic bitTick,
   input wire logic trailDone
);
   logic [2:0] carSync;
   logic [11:0] edgeCnt;
   logic [11:0] sofCnt;
   logic [7:0] tickCnt;
   logic lastBit;
   logic tickSeen;
   wire logic carEdge = carSync[1] & ~carSync[2];
   wire logic [11:0] expMin = lastBit ? MIN_DELAY_ONE : MIN_DELAY_ZERO;
   wire logic [11:0] expNom = lastBit ? NOM_DELAY_ONE : NOM_DELAY_ZERO;
   // carrier edges since frame end and since the last bit tick
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         carSync <= 3'h0;
         edgeCnt <= 12'h000;
         sofCnt <= 12'h000;
         tickCnt <= 8'h00;
         lastBit <= 1'b0;
         tickSeen <= 1'b0;
      end else begin
         carSync <= {carSync[1:0], carrierClk};
         if (rxEnd) begin
            edgeCnt <= 12'h000;
            lastBit <= rxLastBit;
         end else if (carEdge && edgeCnt != 12'hFFF) begin
            edgeCnt <= edgeCnt + 12'h001;
         end
         if (txSof) begin
            sofCnt <= edgeCnt;
         end
         if (txSof || bitTick) begin
            tickCnt <= 8'h00;
         end else if (carEdge && tickCnt != 8'hFF) begin
            tickCnt <= tickCnt + 8'h01;
         end
         if (bitTick || txSof) begin
            tickSeen <= bitTick;
         end
      end
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n);
   sequence firstByte;
      first_match(txSof ##[1:4] txValid);
   endsequence
   chk_sof_pulse: assert property (txSof |=> !txSof)
      else $error("start of frame longer than one cycle");
   chk_min_delay: assert property (firstByte |-> !(txByte inside {8'h08, 8'h27, 8'h20})
      || (sofCnt + 12'h002 >= expMin && sofCnt <= expMin + 12'h002))
      else $error("short answer delay wrong");
   chk_nom_delay: assert property (firstByte |-> !(txByte inside {8'h05, 8'h02, 8'h03})
      || (sofCnt + 12'h002 >= expNom && sofCnt <= expNom + 12'h002))
      else $error("long answer delay wrong");
   chk_crc_flag: assert property (firstByte |-> txAppendCrc == !(txByte inside {8'h08, 8'h27}))
      else $error("crc flag wrong for answer");
   chk_sof_data: assert property (txSof && carrierPresent |-> ##[1:4] txValid)
      else $error("no data after start of frame");
   chk_stall_hold: assert property (txValid && !txReady && carrierPresent |=>
      txValid && $stable(txByte) && $stable(txLast))
      else $error("answer byte changed during stall");
   chk_last_empty: assert property (txValid && txReady && txLast |=> !txValid)
      else $error("data after last byte");
   chk_done_quiet: assert property (trailDone |=> trailDone && !txSof)
      else $error("answer after trail done");
   chk_done_cause: assert property ($rose(trailDone) |-> !carrierPresent)
      else $error("trail done without carrier loss");
   chk_tick_period: assert property (bitTick && tickSeen |-> tickCnt >= 8'h7F && tickCnt <= 8'h81)
      else $error("bit tick period wrong");
   cover property (txSof && txAppendCrc);
   cover property (txValid && !txReady);
   cover property ($rose(trailDone));
   cover property (bitTick && tickSeen);
endmodule
bind type_a_card_emulator_trail type_a_card_emulator_trail_chk i_chk (
   .clk, .reset_n, .ce, .carrierClk, .carrierPresent, .rxValid, .rxByte, .rxEnd, .rxShort,
   .rxTypeB, .rxCrcOk, .rxLastBit, .txSof, .txValid, .txByte, .txLast, .txReady,
   .txAppendCrc, .bitTick, .trailDone
);
`default_nettype wire

// *** testbench/reader_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module reader_model (
   input wire logic clk,
   input wire logic carrierOn,
   input wire logic txValid,
   input wire logic [7:0] txByte,
   input wire logic txLast,
   input wire logic slowStart,
   output logic carrierClk,
   output logic carrierPresent,
   output logic txReady
);
   logic [8:0] got[$];
   int held;
   // carrier toggles only while switched on, stopping it resets the card
   initial begin
      carrierClk = 1'b0;
      #3;
      forever begin
         #40 carrierClk = carrierOn ? ~carrierClk : 1'b0;
      end
   end
   assign carrierPresent = carrierOn;
   // random modulator stalls, keep every accepted byte with its last flag
   // a slow start holds the first byte long enough for two bit ticks
   initial txReady = 1'b0;
   always @(posedge clk) begin
      if (txValid && txReady) begin
         got.push_back({txLast, txByte});
      end
      if (!txValid) begin
         held <= 0;
      end else if (held < 2400) begin
         held <= held + 1;
      end
      txReady <= (!slowStart || held >= 2400) && (($urandom % 4) != 0);
   end
endmodule
`default_nettype wire

// *** testbench/tb_type_a_card_emulator_trail.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb_type_a_card_emulator_trail;
   import card_trail_pkg::*;
   logic clk, reset_n, carrierOn, rxValid, rxEnd, rxShort, rxTypeB, rxCrcOk, rxLastBit, slowStart;
   logic [7:0] rxByte;
   wire logic carrierClk, carrierPresent, txReady, txSof, txValid, txLast;
   wire logic txAppendCrc, bitTick, trailDone;
   wire logic [7:0] txByte;
   int n_mismatch, cmp_count, cycle, edges, endEdge, sofEdge, sofs, doneSofs;
   logic [7:0] fr[$];
   logic [7:0] er[$];
   type_a_card_emulator_trail i_type_a_card_emulator_trail (.clk(clk), .reset_n(reset_n),
      .ce(1'b1), .carrierClk(carrierClk), .carrierPresent(carrierPresent), .rxValid(rxValid),
      .rxByte(rxByte), .rxEnd(rxEnd), .rxShort(rxShort), .rxTypeB(rxTypeB), .rxCrcOk(rxCrcOk),
      .rxLastBit(rxLastBit), .txSof(txSof), .txValid(txValid), .txByte(txByte), .txLast(txLast),
      .txReady(txReady), .txAppendCrc(txAppendCrc), .bitTick(bitTick), .trailDone(trailDone));
   reader_model i_reader_model (.clk(clk), .carrierOn(carrierOn), .txValid(txValid),
      .txByte(txByte), .txLast(txLast), .slowStart(slowStart), .carrierClk(carrierClk),
      .carrierPresent(carrierPresent), .txReady(txReady));
   // system clock
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   // carrier edge count, answer starts and run limit
   always @(posedge carrierClk) edges++;
   always @(posedge clk) begin
      cycle++;
      if (txSof === 1'b1) begin
         sofs++;
         sofEdge = edges;
      end
      if (cycle == 150000) begin
         n_mismatch++;
         tally_and_finish();
      end
   end
   task automatic tally_and_finish();
      if (n_mismatch == 0 && cmp_count > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   task automatic checkVal(string what, logic [8:0] exp, logic [8:0] got);
      cmp_count++;
      if (got !== exp) begin
         n_mismatch++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic checkNear(string what, int exp, int got);
      cmp_count++;
      if (got < exp - 2 || got > exp + 2) begin
         n_mismatch++;
         $display("ERROR %s expected %0d seen %0d", what, exp, got);
      end
   endtask
   // one reader frame, bytes then the end pulse with its flags
   task automatic sendFrame(logic sh, logic tyb, logic crc, logic lb);
      foreach (fr[i]) begin
         @(posedge clk);
         rxValid <= 1'b1;
         rxByte <= fr[i];
      end
      @(posedge clk);
      rxValid <= 1'b0;
      rxEnd <= 1'b1;
      rxShort <= sh;
      rxTypeB <= tyb;
      rxCrcOk <= crc;
      rxLastBit <= lb;
      @(posedge clk);
      rxEnd <= 1'b0;
      endEdge = edges;
   endtask
   task automatic expectAnswer(logic nom, logic lb, logic ac);
      int n;
      int t;
      n = nom ? (lb ? 3156 : 3092) : (lb ? 1236 : 1172);
      t = sofs;
      i_reader_model.got.delete();
      for (int k = 0; k < 30000 && sofs == t; k++) @(posedge clk);
      checkNear("frame delay", n, sofEdge - endEdge);
      checkVal("crc flag", {8'h00, ac}, {8'h00, txAppendCrc});
      for (int k = 0; k < 3000 && i_reader_model.got.size() < er.size(); k++) @(posedge clk);
      checkVal("answer length", 9'(er.size()), 9'(i_reader_model.got.size()));
      foreach (er[i]) checkVal("answer byte", {i == er.size() - 1, er[i]}, i_reader_model.got[i]);
   endtask
   // random last bit; answer checked when one is expected
   task automatic exchange(logic sh, logic tyb, logic crc, logic nom, logic ac);
      logic lb;
      lb = 1'($urandom % 2);
      sendFrame(sh, tyb, crc, lb);
      if (er.size() != 0) expectAnswer(nom, lb, ac);
   endtask
   // frame of another technology, never matches a trail step
   task automatic junk();
      fr = '{{4'hF, 4'($urandom)}};
      repeat ($urandom % 3) fr.push_back(8'($urandom));
      er = {};
      exchange(1'($urandom), 1'($urandom), 1'($urandom), 1'b0, 1'b0);
   endtask
   task automatic carrierReset();
      carrierOn <= 1'b0;
      repeat (50) @(posedge clk);
      carrierOn <= 1'b1;
      repeat (5) @(posedge clk);
   endtask
   initial begin
      reset_n = 1'b0;
      carrierOn = 1'b0;
      {rxValid, rxEnd, rxShort, rxTypeB, rxCrcOk, rxLastBit, slowStart} = 7'h00;
      rxByte = 8'h00;
      void'($urandom(42));
      repeat (5) @(posedge clk);
      reset_n <= 1'b1;
      carrierOn <= 1'b1;
      repeat (5) @(posedge clk);
      junk();
      fr = '{CMD_WAKE_A};
      er = '{8'h08, 8'h03};
      exchange(1'b1, 1'b0, 1'b1, 1'b0, 1'b0);
      fr = '{CMD_HALT, CMD_ZERO};
      er = {};
      exchange(1'b0, 1'b0, 1'b1, 1'b0, 1'b0);
      fr = '{CMD_WAKE_B, CMD_ZERO, CMD_WAKE_B_PARAM};
      exchange(1'b0, 1'b1, 1'b1, 1'b0, 1'b0);
      junk();
      junk();
      carrierReset();
      fr = '{CMD_WAKE_A};
      er = '{8'h08, 8'h03};
      exchange(1'b1, 1'b0, 1'b1, 1'b0, 1'b0);
      fr = '{8'h93, 8'h20};
      er = '{8'h27, 8'hE9, 8'h3B, 8'h11, 8'hE4};
      exchange(1'b0, 1'b0, 1'($urandom), 1'b0, 1'b0);
      fr = '{8'h93, 8'h70, 8'h27, 8'hE9, 8'h3B, 8'h11, 8'hE4};
      er = {};
      exchange(1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
      er = '{8'h20};
      exchange(1'b0, 1'b0, 1'b1, 1'b0, 1'b1);
      fr = '{8'hE0, 8'h80};
      er = '{8'h05, 8'h72, 8'h80, 8'h40, 8'h02};
      slowStart <= 1'b1;
      exchange(1'b0, 1'b0, 1'b1, 1'b1, 1'b1);
      slowStart <= 1'b0;
      junk();
      fr = '{8'h02, 8'h00, 8'hA4, 8'h04, 8'h00, 8'h0E};
      repeat (15) fr.push_back(8'($urandom));
      er = '{8'h02, 8'h00, 8'hA4, 8'h04, 8'h00, 8'h0C};
      for (int i = 1; i <= 12; i++) er.push_back(8'(i));
      er.push_back(8'h00);
      er.push_back(8'h90);
      er.push_back(8'h00);
      exchange(1'b0, 1'b0, 1'b1, 1'b1, 1'b1);
      fr = er[0:18];
      er = '{8'h03, EOT_REMOVAL, 8'h90, 8'h00};
      exchange(1'b0, 1'b0, 1'b1, 1'b1, 1'b1);
      carrierReset();
      checkVal("trail done", 9'h001, {8'h00, trailDone});
      doneSofs = sofs;
      fr = '{CMD_WAKE_A};
      er = {};
      repeat (3) exchange(1'b1, 1'b0, 1'b1, 1'b0, 1'b0);
      repeat (11000) @(posedge clk);
      checkVal("answers after done", 9'(doneSofs), 9'(sofs));
      tally_and_finish();
   end
endmodule
`default_nettype wire
